// ==== dv/fmd_ctl.sv ====
// Purpose: Video controller model on both ports
// Assumes: Driven 2 ns after each rising edge
// Notes:   Released data shows the inverse value
module fmd_ctl (
   // Clocks
   input wire logic    sys_clk,
   input wire logic    rd_clk,
   // Write port
   input wire logic    wr_ready,
   output logic        wr_valid,
   output logic        wr_rst,
   output logic [11:0] wr_data,
   // Read port
   output logic        rd_en,
   output logic        rd_rst,
   input wire logic [11:0] rd_data_ff,
   input wire logic [1:0]  rd_zone_ff,
   input wire logic        rd_valid_ff
);
   timeunit 1ns;
   timeprecision 100ps;
   int stalls = 0; // Refused offers seen
   initial begin
      wr_valid = 1'b0;
      wr_rst = 1'b0;
      wr_data = 12'h000;
      rd_en = 1'b0;
      rd_rst = 1'b0;
   end
   // One field, first word marked, gap cycles between words
   task automatic wr_field(input logic [11:0] base, input int n, input int gap);
      @(posedge sys_clk);
      for (int k = 0; k < n; k++) begin
         #2;
         wr_valid = 1'b1;
         wr_rst = (k == 0);
         wr_data = base + 12'(k);
         do begin
            @(posedge sys_clk);
            if (wr_ready !== 1'b1) stalls++;
         end while (wr_ready !== 1'b1);
         if (gap > 0) begin
            #2;
            wr_valid = 1'b0;
            wr_rst = 1'b0;
            wr_data = ~wr_data;
            repeat (gap) @(posedge sys_clk);
         end
      end
      if (gap == 0) begin
         #2;
         wr_valid = 1'b0;
         wr_rst = 1'b0;
         wr_data = ~wr_data;
      end
   endtask
   // One read; caller spaces reads behind the writer
   task automatic rd_one(input logic r, output logic [11:0] d, output logic [1:0] z,
                         output logic v);
      @(posedge rd_clk);
      #2;
      rd_en = 1'b1;
      rd_rst = r;
      @(posedge rd_clk);
      #2;
      rd_en = 1'b0;
      rd_rst = 1'b0;
      d = rd_data_ff;
      z = rd_zone_ff;
      v = rd_valid_ff;
   endtask
   // Read reset alone for one cycle, no word read
   task automatic rd_restart();
      @(posedge rd_clk);
      #2;
      rd_rst = 1'b1;
      @(posedge rd_clk);
      #2;
      rd_rst = 1'b0;
   endtask
endmodule

// ==== dv/fmd_top_monitor.sv ====
// Purpose: Port checker of the field delay memory
// Assumes: Sees only the top module ports
// Notes:   Read side on rd_clk, write side on sys_clk
module fmd_top_monitor #(
   parameter int DW = 12
) (
   // Write side
   input wire logic          sys_clk,
   input wire logic          resetn,
   input wire logic          wr_valid,
   input wire logic          wr_rst,
   input wire logic [DW-1:0] wr_data,
   input wire logic          wr_ready,
   // Read side
   input wire logic          rd_clk,
   input wire logic          rd_en,
   input wire logic          rd_rst,
   input wire logic [DW-1:0] rd_data_ff,
   input wire logic          rd_valid_ff,
   input wire logic [1:0]    rd_zone_ff
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // Read port answers
   // ----------------------------------------
   chk_rd_answer: assert property (@(posedge rd_clk) disable iff (!resetn)
      rd_en |=> rd_valid_ff) else $error("read not answered");
   chk_rd_pulse: assert property (@(posedge rd_clk) disable iff (!resetn)
      !rd_en |=> !rd_valid_ff) else $error("valid without read");
   chk_rd_hold: assert property (@(posedge rd_clk) disable iff (!resetn)
      !rd_en |=> $stable(rd_data_ff)) else $error("read data moved");
   chk_zone_hold: assert property (@(posedge rd_clk) disable iff (!resetn)
      !rd_en |=> $stable(rd_zone_ff)) else $error("zone moved");
   chk_zone_code: assert property (@(posedge rd_clk) disable iff (!resetn)
      rd_valid_ff |-> rd_zone_ff != 2'b10) else $error("bad zone code");
   // ----------------------------------------
   // Write port flow
   // ----------------------------------------
   chk_rst_ready: assert property (@(posedge sys_clk) disable iff (!resetn)
      $rose(resetn) |-> !wr_ready) else $error("ready in reset");
   chk_fill_cause: assert property (@(posedge sys_clk) disable iff (!resetn)
      $fell(wr_ready) |-> $past(wr_valid && wr_ready)) else $error("ready fell idle");
   chk_fill_drain: assert property (@(posedge sys_clk) disable iff (!resetn)
      $fell(wr_ready) |-> ##[1:8] wr_ready) else $error("fifo never drains");
endmodule

bind fmd_top fmd_top_monitor #(.DW(DW)) fmd_top_monitor_i (
   .sys_clk(sys_clk), .resetn(resetn), .wr_valid(wr_valid), .wr_rst(wr_rst),
   .wr_data(wr_data), .wr_ready(wr_ready), .rd_clk(rd_clk), .rd_en(rd_en),
   .rd_rst(rd_rst), .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff),
   .rd_zone_ff(rd_zone_ff));

// ==== dv/fmd_top_tb.sv ====
// Purpose: Self-checking bench of the field delay memory
// Assumes: Depth lowered to 512 words
// Notes:   Writer idle while new or old data is judged
module fmd_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        sys_clk = 1'b0; // Write clock
   logic        rd_clk = 1'b0;  // Read clock
   logic        resetn = 1'b0;  // Reset, active low
   logic        wr_valid, wr_rst, wr_ready, rd_en, rd_rst, rd_valid_ff;
   logic [11:0] wr_data, rd_data_ff;
   logic [1:0]  rd_zone_ff;
   int          miscompares = 0;
   int          n_tests = 0;
   initial forever #25 sys_clk = ~sys_clk;
   initial begin
      #13;
      forever #62.5 rd_clk = ~rd_clk;
   end
   fmd_top #(.DEPTH(512)) fmd_top_i (.sys_clk(sys_clk), .resetn(resetn),
      .wr_valid(wr_valid), .wr_rst(wr_rst), .wr_data(wr_data), .wr_ready(wr_ready),
      .rd_clk(rd_clk), .rd_en(rd_en), .rd_rst(rd_rst), .rd_data_ff(rd_data_ff),
      .rd_valid_ff(rd_valid_ff), .rd_zone_ff(rd_zone_ff));
   fmd_ctl fmd_ctl_i (.sys_clk(sys_clk), .rd_clk(rd_clk), .wr_ready(wr_ready),
      .wr_valid(wr_valid), .wr_rst(wr_rst), .wr_data(wr_data), .rd_en(rd_en),
      .rd_rst(rd_rst), .rd_data_ff(rd_data_ff), .rd_zone_ff(rd_zone_ff),
      .rd_valid_ff(rd_valid_ff));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   // Full-speed field fills the fifo, then far-behind reads
   task automatic t_new();
      logic [11:0] d;
      logic [1:0]  z;
      logic        v;
      fmd_ctl_i.wr_field(12'h100, 400, 0);
      check(16'(fmd_ctl_i.stalls != 0), 16'h0001);
      repeat (40) @(posedge sys_clk);
      for (int k = 0; k < 200; k++) begin
         fmd_ctl_i.rd_one(k == 0, d, z, v);
         check({4'h0, d}, 16'h0100 + 16'(k));
         check({14'h0, z}, 16'h0003);
         if (k == 0) check({15'h0, v}, 16'h0001);
      end
   endtask
   // Short slow field, reads close behind the writer
   task automatic t_old();
      logic [11:0] d;
      logic [1:0]  z;
      logic        v;
      fmd_ctl_i.wr_field(12'h600, 50, 3);
      repeat (20) @(posedge sys_clk);
      for (int k = 0; k < 50; k++) begin
         fmd_ctl_i.rd_one(k == 0, d, z, v);
         if (k < 26) check({14'h0, z}, 16'h0001);
         if (k > 34) check({4'h0, d}, 16'h0100 + 16'(k));
         if (k > 34) check({14'h0, z}, 16'h0000);
      end
   endtask
   // Writes made while the reader runs close, then verified
   task automatic t_undef();
      logic [11:0] d;
      logic [1:0]  z;
      logic        v;
      fork
         fmd_ctl_i.wr_field(12'h300, 300, 0);
         for (int k = 0; k < 40; k++) fmd_ctl_i.rd_one(k == 0, d, z, v);
      join
      repeat (40) @(posedge sys_clk);
      fmd_ctl_i.rd_restart();
      check({15'h0, rd_valid_ff}, 16'h0000);
      for (int k = 0; k < 100; k++) begin
         fmd_ctl_i.rd_one(1'b0, d, z, v);
         check({4'h0, d}, 16'h0300 + 16'(k));
         check({14'h0, z}, 16'h0003);
      end
   endtask
   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (12) @(posedge sys_clk);
      #2;
      resetn = 1'b1;
      repeat (5) @(posedge rd_clk);
      t_new();
      t_old();
      t_undef();
      complete_run();
   end
   initial begin
      #1_000_000;
      miscompares++;
      complete_run();
   end
endmodule

// ==== rtl/fmd_fifo.sv ====
// Purpose: Small synchronous FIFO in the write data path
// Assumes: Both sides on one clock, depth a power of two
// Notes:   in_ready is a flop; out_valid follows the count
module fmd_fifo #(
   parameter int W = 13,
   parameter int D = 16
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         resetn,
   // Filling side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Draining side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);

   // Refuse depths the pointers cannot serve
   if (D < 2 || (1 << AW) != D || W < 1) begin : g_bad_depth
      $error("fmd_fifo: D must be a power of two >= 2");
   end

   logic [W-1:0] mem [D];         // Storage words
   logic [AW-1:0] wp_ff;          // Write pointer
   logic [AW-1:0] rp_ff;          // Read pointer
   logic [AW:0]   cnt_ff;         // Words held
   logic          rdy_ff;         // Room for one more
   logic [AW-1:0] nxt_wp;
   logic [AW-1:0] nxt_rp;
   logic [AW:0]   nxt_cnt;
   logic          nxt_rdy;
   logic          push;
   logic          pop;

   assign out_valid = (cnt_ff != '0);
   assign out_data  = mem[rp_ff];
   assign in_ready  = rdy_ff;

   // Pointer and count update
   always_comb begin
      push    = in_valid && rdy_ff;
      pop     = out_valid && out_ready;
      nxt_wp  = push ? wp_ff + AW'(1) : wp_ff;
      nxt_rp  = pop ? rp_ff + AW'(1) : rp_ff;
      nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      nxt_rdy = (nxt_cnt < (AW+1)'(D));
   end

   // Register pointers and flags
   always_ff @(posedge clk) begin
      if (!resetn) begin
         wp_ff  <= '0;
         rp_ff  <= '0;
         cnt_ff <= '0;
         rdy_ff <= 1'b0;
      end else begin
         wp_ff  <= nxt_wp;
         rp_ff  <= nxt_rp;
         cnt_ff <= nxt_cnt;
         rdy_ff <= nxt_rdy;
      end
   end

   // Storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_ff] <= in_data;
      end
   end
endmodule

// ==== rtl/fmd_pkg.sv ====
// Purpose: Types of the field delay memory
// Assumes: Nothing is imported; users write fmd_pkg::name
// Notes:   Enum codes are Gray along the usual path
package fmd_pkg;

   // Write engine states: take a word, then store it
   typedef enum logic {
      ENG_TAKE  = 1'b0,
      ENG_STORE = 1'b1
   } fmd_eng_t;

   // Class of the last read word
   typedef enum logic [1:0] {
      ZONE_OLD   = 2'b00,
      ZONE_UNDEF = 2'b01,
      ZONE_NEW   = 2'b11
   } fmd_zone_t;

endpackage

// ==== rtl/fmd_regs.svh ====
// Purpose: Constants of the field delay memory
// Assumes: Included by bare name from the design files
// Notes:   Counts are in memory locations, not clock cycles
`ifndef FMD_REGS_SVH
`define FMD_REGS_SVH

// ----------------------------------------
// Lag thresholds
// ----------------------------------------
`define FMD_NEW_LAG      150
`define FMD_OLD_LAG      20

// ----------------------------------------
// Geometry defaults
// ----------------------------------------
`define FMD_DEPTH        262214
`define FMD_DATA_W       12
`define FMD_FIFO_D       16

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FMD_ADDR_RST     0
`define FMD_DATA_RST     0

`endif

// ==== rtl/fmd_top.sv ====
// Purpose: Field delay memory with separate write and read ports
// Assumes: Write port on sys_clk, read port on rd_clk
// Notes:   Each word keeps its previous field copy for old reads
`include "fmd_regs.svh"

module fmd_top #(
   parameter int DEPTH  = `FMD_DEPTH,
   parameter int DW     = `FMD_DATA_W,
   parameter int FIFO_D = `FMD_FIFO_D
) (
   // System clock and reset
   input  wire logic          sys_clk,
   input  wire logic          resetn,
   // Write port, sys_clk domain
   input  wire logic          wr_valid,
   input  wire logic          wr_rst,
   input  wire logic [DW-1:0] wr_data,
   output logic               wr_ready,
   // Read port, rd_clk domain
   input  wire logic          rd_clk,
   input  wire logic          rd_en,
   input  wire logic          rd_rst,
   output logic [DW-1:0]      rd_data_ff,
   output logic               rd_valid_ff,
   output logic [1:0]         rd_zone_ff
);
   localparam int AW = $clog2(DEPTH);

   // Refuse geometries the lag logic cannot serve
   if (DEPTH <= `FMD_NEW_LAG || DW < 1 || FIFO_D < 2) begin : g_bad_geom
      $error("fmd_top: DEPTH must exceed the new-data lag");
   end

   // ----------------------------------------
   // Shared functions
   // ----------------------------------------

   // Next location, wrapping at the last word
   function automatic logic [AW-1:0] inc_f(input logic [AW-1:0] a);
      inc_f = (a == AW'(DEPTH - 1)) ? '0 : a + AW'(1);
   endfunction

   // Locations by which read trails write
   // Counted modulo DEPTH, so after the writer has wrapped the reader
   // still sees its true distance behind the writer
   function automatic logic [AW-1:0] lag_f(input logic [AW-1:0] wa,
                                           input logic [AW-1:0] ra);
      logic [AW:0] s;
      s = (AW+1)'(wa) + (AW+1)'(DEPTH) - (AW+1)'(ra);
      lag_f = (wa >= ra) ? wa - ra : s[AW-1:0];
   endfunction

   // ----------------------------------------
   // Storage arrays, written on sys_clk only
   // ----------------------------------------
   // Two copies per word let an old read survive a rewrite: the
   // parity tag tells whether cur_mem already holds this field.
   // Limitation: a word skipped for a whole field aliases its tag,
   // so an old read there may return a copy two fields back.
   logic [DW-1:0] cur_mem  [DEPTH];  // Latest write of each word
   logic [DW-1:0] prev_mem [DEPTH];  // Word of the field before
   logic          tag_mem  [DEPTH];  // Field parity of latest write

   // ----------------------------------------
   // Write path FIFO
   // ----------------------------------------
   logic          f_valid;           // Word waiting at FIFO head
   logic          f_ready;           // Engine takes the head
   logic [DW:0]   f_data;            // {reset mark, data}
   logic          f_in_ready;        // Room in the FIFO

   // Back-pressure reaches the controller through wr_ready
   // The reset mark rides in the top bit so it stays with its word
   fmd_fifo #(
      .W (DW + 1),
      .D (FIFO_D)
   ) fmd_fifo_i (
      .clk       (sys_clk),
      .resetn    (resetn),
      .in_valid  (wr_valid),
      .in_ready  (f_in_ready),
      .in_data   ({wr_rst, wr_data}),
      .out_valid (f_valid),
      .out_ready (f_ready),
      .out_data  (f_data)
   );

   assign wr_ready = f_in_ready;

   // ----------------------------------------
   // Write engine, sys_clk domain
   // ----------------------------------------
   fmd_pkg::fmd_eng_t eng_ff;        // Engine state
   logic [DW-1:0] word_ff;           // Word being stored
   logic [AW-1:0] st_addr_ff;        // Location being stored
   logic [AW-1:0] wr_addr_ff;        // Next write location
   logic          field_ff;          // Current write field parity
   fmd_pkg::fmd_eng_t nxt_eng;
   logic [DW-1:0] nxt_word;
   logic [AW-1:0] nxt_st_addr;
   logic [AW-1:0] nxt_wr_addr;
   logic          nxt_field;
   logic          do_store;          // Commit word this cycle

   // Two cycles per word give the commit time to move the older
   // copy aside; the FIFO absorbs bursts at the full port rate
   // Take one word, then store it; the second cycle stalls the FIFO
   always_comb begin
      nxt_eng     = eng_ff;
      nxt_word    = word_ff;
      nxt_st_addr = st_addr_ff;
      nxt_wr_addr = wr_addr_ff;
      nxt_field   = field_ff;
      f_ready     = 1'b0;
      do_store    = 1'b0;
      unique case (eng_ff)
         fmd_pkg::ENG_TAKE: begin
            if (f_valid) begin
               f_ready  = 1'b1;
               nxt_word = f_data[DW-1:0];
               nxt_eng  = fmd_pkg::ENG_STORE;
               // Reset mark starts a new field at location zero
               if (f_data[DW]) begin
                  nxt_st_addr = AW'(`FMD_ADDR_RST);
                  nxt_field   = ~field_ff;
               end else begin
                  nxt_st_addr = wr_addr_ff;
               end
            end
         end
         fmd_pkg::ENG_STORE: begin
            // Stores regardless of where the reader stands
            do_store    = 1'b1;
            nxt_wr_addr = inc_f(st_addr_ff);
            nxt_eng     = fmd_pkg::ENG_TAKE;
         end
      endcase
   end

   // Register engine state
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         eng_ff     <= fmd_pkg::ENG_TAKE;
         word_ff    <= DW'(`FMD_DATA_RST);
         st_addr_ff <= AW'(`FMD_ADDR_RST);
         wr_addr_ff <= AW'(`FMD_ADDR_RST);
         field_ff   <= 1'b0;
      end else begin
         eng_ff     <= nxt_eng;
         word_ff    <= nxt_word;
         st_addr_ff <= nxt_st_addr;
         wr_addr_ff <= nxt_wr_addr;
         field_ff   <= nxt_field;
      end
   end

   // Commit: older copy moves aside when the field changes
   always_ff @(posedge sys_clk) begin
      if (do_store) begin
         if (tag_mem[st_addr_ff] != field_ff) begin
            prev_mem[st_addr_ff] <= cur_mem[st_addr_ff];
         end
         cur_mem[st_addr_ff] <= word_ff;
         tag_mem[st_addr_ff] <= field_ff;
      end
   end

   // ----------------------------------------
   // Write position handshake to read side
   // ----------------------------------------
   // The write position crosses as one word under a toggle
   // handshake; the snapshot holds still until the read side
   // acknowledges, so no bit of it is caught mid-change.
   // The read side therefore sees a position a few cycles stale,
   // which the margins of the lag zones easily cover.
   logic [AW:0]   snap_ff;           // {field, next write location}
   logic          req_ff;            // Toggles per snapshot
   logic          ack_s1_ff;         // Ack synchroniser, first
   logic          ack_s2_ff;         // Ack synchroniser, second
   logic          ack_ff;            // Ack toggle, rd_clk domain
   logic [AW:0]   nxt_snap;
   logic          nxt_req;

   // New snapshot only once the last one was acknowledged
   always_comb begin
      nxt_snap = snap_ff;
      nxt_req  = req_ff;
      if (ack_s2_ff == req_ff) begin
         nxt_snap = {field_ff, wr_addr_ff};
         nxt_req  = ~req_ff;
      end
   end

   // Register snapshot and request
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         snap_ff <= '0;
         req_ff  <= 1'b0;
      end else begin
         snap_ff <= nxt_snap;
         req_ff  <= nxt_req;
      end
   end

   // Bring the acknowledge into sys_clk
   always_ff @(posedge sys_clk) begin
      ack_s1_ff <= ack_ff;
      ack_s2_ff <= ack_s1_ff;
   end

   // ----------------------------------------
   // Read side, rd_clk domain
   // ----------------------------------------
   logic          rrst_s1_ff;        // Reset synchroniser, first
   logic          rrst_s2_ff;        // Reset synchroniser, second
   logic          rq_s1_ff;          // Request synchroniser, first
   logic          rq_s2_ff;          // Request synchroniser, second
   logic          rq_s3_ff;          // Request edge history
   logic [AW:0]   wsnap_ff;          // Write position seen here
   logic [AW-1:0] rd_addr_ff;        // Next read location
   logic          nxt_ack;
   logic [AW:0]   nxt_wsnap;
   logic [AW-1:0] nxt_rd_addr;
   logic [DW-1:0] nxt_rd_data;
   logic          nxt_rd_valid;
   logic [1:0]    nxt_rd_zone;
   logic [AW-1:0] sel_addr;          // Location read this cycle
   logic [AW-1:0] lag;               // Read trails write by this
   fmd_pkg::fmd_zone_t zone;         // Class of this read

   // Reset and request crossings into rd_clk
   always_ff @(posedge rd_clk) begin
      rrst_s1_ff <= resetn;
      rrst_s2_ff <= rrst_s1_ff;
      rq_s1_ff   <= req_ff;
      rq_s2_ff   <= rq_s1_ff;
   end

   // Memories are read across the clock boundary; writer and reader
   // only meet inside the unspecified zone, where any word will do
   // Acknowledge echoes the request level once the word is caught
   // Snapshot capture and read port
   always_comb begin
      nxt_ack   = ack_ff;
      nxt_wsnap = wsnap_ff;
      // Snapshot is stable while the request is pending
      if (rq_s2_ff != rq_s3_ff) begin
         nxt_wsnap = snap_ff;
         nxt_ack   = rq_s2_ff;
      end
      // Read reset restarts at location zero
      sel_addr = rd_rst ? AW'(`FMD_ADDR_RST) : rd_addr_ff;
      lag      = lag_f(wsnap_ff[AW-1:0], sel_addr);
      // Controller must hold lag above the new-data mark
      // Lag of exactly 20 or 150 falls on the unspecified side
      if (lag > AW'(`FMD_NEW_LAG)) begin
         zone = fmd_pkg::ZONE_NEW;
      end else if (lag < AW'(`FMD_OLD_LAG)) begin
         zone = fmd_pkg::ZONE_OLD;
      end else begin
         zone = fmd_pkg::ZONE_UNDEF;
      end
      nxt_rd_addr  = rd_addr_ff;
      nxt_rd_data  = rd_data_ff;
      nxt_rd_zone  = rd_zone_ff;
      nxt_rd_valid = 1'b0;
      if (rd_en) begin
         nxt_rd_addr  = inc_f(sel_addr);
         nxt_rd_valid = 1'b1;
         nxt_rd_zone  = zone;
         // Old read skips words already rewritten this field
         if (zone == fmd_pkg::ZONE_OLD && tag_mem[sel_addr] == wsnap_ff[AW]) begin
            nxt_rd_data = prev_mem[sel_addr];
         end else begin
            // New data, unspecified-zone data, or an old word not yet rewritten this field
            nxt_rd_data = cur_mem[sel_addr];
         end
      end else if (rd_rst) begin
         nxt_rd_addr = AW'(`FMD_ADDR_RST);
      end
   end

   // Register read side state
   // Read outputs clear only once the synchronised reset arrives
   always_ff @(posedge rd_clk) begin
      if (!rrst_s2_ff) begin
         rq_s3_ff    <= 1'b0;
         ack_ff      <= 1'b0;
         wsnap_ff    <= '0;
         rd_addr_ff  <= AW'(`FMD_ADDR_RST);
         rd_data_ff  <= DW'(`FMD_DATA_RST);
         rd_valid_ff <= 1'b0;
         rd_zone_ff  <= fmd_pkg::ZONE_OLD;
      end else begin
         rq_s3_ff    <= rq_s2_ff;
         ack_ff      <= nxt_ack;
         wsnap_ff    <= nxt_wsnap;
         rd_addr_ff  <= nxt_rd_addr;
         rd_data_ff  <= nxt_rd_data;
         rd_valid_ff <= nxt_rd_valid;
         rd_zone_ff  <= nxt_rd_zone;
      end
   end
endmodule
